// ===== csw_pkg.sv
// package for the chip select and wait state unit
//
// Functional notes
// RULE1 - upper block size code picks upper region
// RULE2 - address disable honoured only if strap high
// RULE3 - upper disable bit drops address phase
// RULE4 - upper ready ignore bit skips external ready
// RULE5 - upper waits from bits 3,1,0, reset 15
// RULE6 - lower region is 1M minus upper size
// RULE7 - lower select off until register accessed
// RULE8 - lower disable bit drops address phase
// RULE9 - software keeps peripheral block outside regions
// RULE10 - peripheral selects off until both written
// RULE11 - io mapping needs base top bits zero
// RULE12 - peripheral selects in 256 byte windows; code never asserts select 4, its window decodes to no select
// RULE13 - first state waits 0..11 for peripherals
// RULE14 - ready ignore bit for selects 3..0
// RULE15 - third state waits 0..15 for 3..0
// RULE16 - space bit zero means io cycles only
// RULE17 - ready ignore bit for select five
// RULE18 - third state waits 0..3 for five
// RULE19 - upper select enabled at reset, 15 waits
// RULE20 - external party holds ready low to stretch
// RULE21 - one select per cycle, held throughout
// RULE22 - reserved bits read fixed, writes ignored
`default_nettype none

package csw_pkg;

  // ==========================================================
  // register offsets
  localparam logic [7:0] UPPER_OFS  = 8'ha0;
  localparam logic [7:0] LOWER_OFS  = 8'ha2;
  localparam logic [7:0] PERIPH0_OFS = 8'ha4;
  localparam logic [7:0] PERIPH1_OFS = 8'ha8;

  // ==========================================================
  // reset values and writable masks
  localparam logic [15:0] UPPER_RST   = 16'hf03b;
  localparam logic [15:0] UPPER_WMASK = 16'h708f;
  localparam logic [15:0] UPPER_FIXED = 16'h8030;
  localparam logic [15:0] LOWER_RST   = 16'h0000;
  localparam logic [15:0] LOWER_WMASK = 16'h0080;
  localparam logic [15:0] LOWER_FIXED = 16'h003f;
  localparam logic [15:0] PER0_RST    = 16'h0000;
  localparam logic [15:0] PER0_WMASK  = 16'hff7f;
  localparam logic [15:0] PER1_RST    = 16'h0000;
  localparam logic [15:0] PER1_WMASK  = 16'h0047;
  localparam logic [15:0] PER1_FIXED  = 16'h0038;

  // ==========================================================
  // field positions
  localparam int BLK_LSB    = 12;
  localparam int DISABLE_B  = 7;
  localparam int SPACE_B    = 6;
  localparam int WAIT1_LSB  = 4;
  localparam int RDYIGN_B   = 2;
  localparam int BASE_LSB   = 8;

  // ==========================================================
  // bus cycle state machine
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_FIRST = 3'b001,
    ST_MID   = 3'b010,
    ST_THIRD = 3'b011,
    ST_READY = 3'b100,
    ST_END   = 3'b101
  } csw_state_e;

  // bus cycle request from the core
  typedef struct packed {
    logic        is_io;
    logic [19:0] addr;
  } csw_req_s;

  // select outputs
  typedef struct packed {
    logic       upper_n;
    logic       lower_n;
    logic [5:0] periph_n;
  } csw_sel_s;

endpackage : csw_pkg

`default_nettype wire

// ===== csw_unit.sv
// chip select decoder and wait state generator
`default_nettype none

module csw_unit
  import csw_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        srst,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output var  logic [15:0] reg_rdata,
  input  wire logic        addr_phase_strap_pin,
  input  wire logic        cyc_start,
  input  wire csw_req_s    cyc_req,
  input  wire logic        external_ready,
  output var  csw_sel_s    sel_n,
  output var  logic        addr_phase_enable,
  output var  logic        cyc_busy,
  output var  logic        cyc_done,
  output var  logic        cyc_unmapped
);

  // ==========================================================
  // wait code decoders
  function automatic logic [3:0] wait_code8(input logic [2:0] c, input logic top15);
    case (c)
      3'b000:  wait_code8 = 4'h0;
      3'b001:  wait_code8 = 4'h1;
      3'b010:  wait_code8 = 4'h2;
      3'b011:  wait_code8 = 4'h3;
      3'b100:  wait_code8 = 4'h5;
      3'b101:  wait_code8 = 4'h7;
      3'b110:  wait_code8 = 4'h9;
      default: wait_code8 = top15 ? 4'hf : 4'hb;
    endcase
  endfunction : wait_code8

  // upper region start address top bits from block size
  function automatic logic [3:0] upper_start(input logic [2:0] blk);
    case (blk)
      3'b111:  upper_start = 4'hf;
      3'b110:  upper_start = 4'he;
      3'b100:  upper_start = 4'hc;
      3'b101:  upper_start = 4'he;
      default: upper_start = 4'h8;
    endcase
  endfunction : upper_start

  // ==========================================================
  // registers
  logic [15:0] upper_ff;
  logic [15:0] lower_ff;
  logic [15:0] per0_ff;
  logic [15:0] per1_ff;
  logic        lower_on_ff;
  logic        per0_wr_ff;
  logic        per1_wr_ff;
  logic        strap_ff;
  logic        rst_seen_ff;

  // upper select control, reset enables code fetch with 15 waits
  always_ff @(posedge core_clk) begin
    if (srst) begin
      upper_ff <= UPPER_RST; // [RULE19]
    end else if (reg_wr && reg_addr == UPPER_OFS) begin
      upper_ff <= (reg_wdata & UPPER_WMASK) | UPPER_FIXED; // [RULE22]
    end
  end

  // lower select control
  always_ff @(posedge core_clk) begin
    if (srst) begin
      lower_ff <= LOWER_RST;
    end else if (reg_wr && reg_addr == LOWER_OFS) begin
      lower_ff <= reg_wdata & LOWER_WMASK; // [RULE22]
    end
  end

  // lower select activation on any access
  always_ff @(posedge core_clk) begin
    if (srst) begin
      lower_on_ff <= 1'b0; // [RULE7]
    end else if ((reg_wr || reg_rd) && reg_addr == LOWER_OFS) begin
      lower_on_ff <= 1'b1; // [RULE7]
    end
  end

  // peripheral control registers
  always_ff @(posedge core_clk) begin
    if (srst) begin
      per0_ff <= PER0_RST;
    end else if (reg_wr && reg_addr == PERIPH0_OFS) begin
      per0_ff <= reg_wdata & PER0_WMASK; // [RULE22]
    end
  end

  // first peripheral register written since reset
  always_ff @(posedge core_clk) begin
    if (srst) begin
      per0_wr_ff <= 1'b0;
    end else if (reg_wr && reg_addr == PERIPH0_OFS) begin
      per0_wr_ff <= 1'b1; // [RULE10]
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      per1_ff <= PER1_RST;
    end else if (reg_wr && reg_addr == PERIPH1_OFS) begin
      per1_ff <= reg_wdata & PER1_WMASK; // [RULE22]
    end
  end

  // second peripheral register written since reset
  always_ff @(posedge core_clk) begin
    if (srst) begin
      per1_wr_ff <= 1'b0;
    end else if (reg_wr && reg_addr == PERIPH1_OFS) begin
      per1_wr_ff <= 1'b1; // [RULE10]
    end
  end

  // marks the first clock after reset release
  always_ff @(posedge core_clk) begin
    if (srst) begin
      rst_seen_ff <= 1'b0;
    end else begin
      rst_seen_ff <= 1'b1;
    end
  end

  // strap captured at the first clock after reset release
  always_ff @(posedge core_clk) begin
    if (srst) begin
      strap_ff <= 1'b0;
    end else if (!rst_seen_ff) begin
      strap_ff <= addr_phase_strap_pin; // [RULE2]
    end
  end

  // register read port, data one cycle after strobe
  always_ff @(posedge core_clk) begin
    if (srst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      case (reg_addr)
        UPPER_OFS:   reg_rdata <= upper_ff;
        LOWER_OFS:   reg_rdata <= lower_ff | LOWER_FIXED; // [RULE22]
        PERIPH0_OFS: reg_rdata <= per0_ff;
        PERIPH1_OFS: reg_rdata <= per1_ff | PER1_FIXED; // [RULE22]
        default:     reg_rdata <= 16'h0000;
      endcase
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  // ==========================================================
  // address decode
  logic       hit_upper;
  logic       hit_lower;
  logic [5:0] hit_per;
  logic       per_space_ok;
  logic [19:0] per_base;
  logic [19:0] per_off;
  logic [2:0]  per_idx;

  always_comb begin
    hit_upper = !cyc_req.is_io &&
                cyc_req.addr[19:16] >= upper_start(upper_ff[BLK_LSB +: 3]); // [RULE1]
    // lower region covers everything below the upper start
    hit_lower = lower_on_ff && !cyc_req.is_io && !hit_upper; // [RULE6]
    per_base  = {per0_ff[15:BASE_LSB], 12'h000};
    per_off   = cyc_req.addr - per_base;
    per_idx   = per_off[10:8];
    per_space_ok = per1_ff[SPACE_B] ? 1'b1 : cyc_req.is_io; // [RULE16]
    hit_per   = 6'b000000;
    if (per0_wr_ff && per1_wr_ff && per_space_ok && // [RULE10]
        cyc_req.addr >= per_base && per_off < 20'h00600 && per_idx != 3'd4) begin
      hit_per[per_idx] = 1'b1; // [RULE12]
    end
  end

  // ==========================================================
  // bus cycle sequencer
  csw_state_e  state_ff;
  csw_state_e  nxt_state;
  logic [3:0]  wcnt_ff;
  logic [3:0]  nxt_wcnt;
  logic [3:0]  wait1_ff;
  logic [3:0]  wait3_ff;
  logic        rdy_req_ff;
  csw_sel_s    nxt_sel;
  logic        nxt_aen;

  // select and timing choice at cycle start, one select only
  always_comb begin
    nxt_sel = '{upper_n: 1'b1, lower_n: 1'b1, periph_n: 6'h3f};
    nxt_aen = 1'b1;
    if (hit_per != 6'b000000) begin
      nxt_sel.periph_n = ~hit_per; // [RULE21]
    end else if (hit_upper) begin
      nxt_sel.upper_n = 1'b0; // [RULE21]
      nxt_aen = !(strap_ff && upper_ff[DISABLE_B]); // [RULE2] [RULE3]
    end else if (hit_lower) begin
      nxt_sel.lower_n = 1'b0; // [RULE21]
      nxt_aen = !(strap_ff && lower_ff[DISABLE_B]); // [RULE8]
    end
  end

  // a cycle is taken only from idle
  logic        cyc_take;
  assign cyc_take = (state_ff == ST_IDLE) && cyc_start;

  // selects held from cycle start through the end state
  always_ff @(posedge core_clk) begin
    if (srst) begin
      sel_n <= '{upper_n: 1'b1, lower_n: 1'b1, periph_n: 6'h3f};
    end else if (cyc_take) begin
      sel_n <= nxt_sel; // [RULE21]
    end else if (state_ff == ST_END) begin
      sel_n <= '{upper_n: 1'b1, lower_n: 1'b1, periph_n: 6'h3f};
    end
  end

  // address phase choice for the taken cycle
  always_ff @(posedge core_clk) begin
    if (srst) begin
      addr_phase_enable <= 1'b1;
    end else if (cyc_take) begin
      addr_phase_enable <= nxt_aen; // [RULE3] [RULE8]
    end else if (state_ff == ST_END) begin
      addr_phase_enable <= 1'b1;
    end
  end

  // flags a cycle that no select decoded
  always_ff @(posedge core_clk) begin
    if (srst) begin
      cyc_unmapped <= 1'b0;
    end else if (cyc_take) begin
      cyc_unmapped <= (&nxt_sel);
    end else if (state_ff == ST_END) begin
      cyc_unmapped <= 1'b0;
    end
  end

  // first state wait count for peripheral cycles
  always_ff @(posedge core_clk) begin
    if (srst) begin
      wait1_ff <= 4'h0;
    end else if (cyc_take) begin
      if (hit_per != 6'b000000) begin
        wait1_ff <= wait_code8(per0_ff[WAIT1_LSB +: 3], 1'b0); // [RULE13]
      end else begin
        wait1_ff <= 4'h0;
      end
    end
  end

  // third state wait count of the decoded select
  always_ff @(posedge core_clk) begin
    if (srst) begin
      wait3_ff <= 4'h0;
    end else if (cyc_take) begin
      if (hit_per[5]) begin
        wait3_ff <= {2'b00, per1_ff[1:0]}; // [RULE18]
      end else if (hit_per != 6'b000000) begin
        wait3_ff <= wait_code8({per0_ff[3], per0_ff[1:0]}, 1'b1); // [RULE15]
      end else if (hit_upper) begin
        wait3_ff <= wait_code8({upper_ff[3], upper_ff[1:0]}, 1'b1); // [RULE5]
      end else begin
        wait3_ff <= 4'h0;
      end
    end
  end

  // ready policy of the decoded select
  always_ff @(posedge core_clk) begin
    if (srst) begin
      rdy_req_ff <= 1'b0;
    end else if (cyc_take) begin
      if (hit_per[5]) begin
        rdy_req_ff <= !per1_ff[RDYIGN_B]; // [RULE17]
      end else if (hit_per != 6'b000000) begin
        rdy_req_ff <= !per0_ff[RDYIGN_B]; // [RULE14]
      end else if (hit_upper) begin
        rdy_req_ff <= !upper_ff[RDYIGN_B]; // [RULE4]
      end else begin
        rdy_req_ff <= 1'b0;
      end
    end
  end

  // state and wait counter progression
  always_comb begin
    nxt_state = state_ff;
    nxt_wcnt  = wcnt_ff;
    case (state_ff)
      ST_IDLE: begin
        if (cyc_start) begin
          nxt_state = ST_FIRST;
        end
      end
      ST_FIRST: begin
        nxt_wcnt  = wait1_ff;
        nxt_state = ST_MID;
      end
      ST_MID: begin
        if (wcnt_ff == 4'h0) begin
          nxt_wcnt  = wait3_ff;
          nxt_state = ST_THIRD;
        end else begin
          nxt_wcnt = wcnt_ff - 4'h1; // first state waits [RULE13]
        end
      end
      ST_THIRD: begin
        if (wcnt_ff == 4'h0) begin
          nxt_state = ST_READY;
        end else begin
          nxt_wcnt = wcnt_ff - 4'h1; // third state waits [RULE5] [RULE15]
        end
      end
      ST_READY: begin
        // stretch while ready is low and required
        if (!rdy_req_ff || external_ready) begin // [RULE4] [RULE20]
          nxt_state = ST_END;
        end
      end
      ST_END: begin
        nxt_state = ST_IDLE;
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // bus cycle state register
  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // wait state down counter
  always_ff @(posedge core_clk) begin
    if (srst) begin
      wcnt_ff <= 4'h0;
    end else begin
      wcnt_ff <= nxt_wcnt;
    end
  end

  // busy level, high while not idle
  always_ff @(posedge core_clk) begin
    if (srst) begin
      cyc_busy <= 1'b0;
    end else begin
      cyc_busy <= (nxt_state != ST_IDLE);
    end
  end

  // done pulse, one cycle after the end state
  always_ff @(posedge core_clk) begin
    if (srst) begin
      cyc_done <= 1'b0;
    end else begin
      cyc_done <= (state_ff == ST_END);
    end
  end

endmodule : csw_unit

`default_nettype wire

// ===== csw_unit_chk.sv
// assertion checker for the chip select unit
`default_nettype none
module csw_unit_chk
  import csw_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        srst,
  input wire logic [7:0]  reg_addr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic        addr_phase_strap_pin,
  input wire logic        cyc_start,
  input wire csw_req_s    cyc_req,
  input wire csw_sel_s    sel_n,
  input wire logic        addr_phase_enable,
  input wire logic        cyc_busy,
  input wire logic        cyc_unmapped
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  // ====================
  // strap seen at reset release
  logic rst_ff;
  logic strap_ff;
  always_ff @(posedge core_clk) begin
    rst_ff <= srst;
    if (rst_ff && !srst) strap_ff <= addr_phase_strap_pin;
  end
  // ====================
  // properties
  property p_one_sel; $countones(~sel_n) <= 1; endproperty
  a_one_sel: assert property (p_one_sel) else $error("two selects low");
  property p_idle; !cyc_busy |-> &sel_n; endproperty
  a_idle: assert property (p_idle) else $error("select low while idle");
  property p_hold; cyc_busy && $past(cyc_busy) |-> $stable(sel_n); endproperty
  a_hold: assert property (p_hold) else $error("select moved in cycle");
  property p_unmap; cyc_unmapped |-> &sel_n; endproperty
  a_unmap: assert property (p_unmap) else $error("select on unmapped");
  property p_busy; cyc_start && !cyc_busy |=> cyc_busy [*4]; endproperty
  a_busy: assert property (p_busy) else $error("cycle too short");
  property p_io;
    cyc_start && !cyc_busy && cyc_req.is_io |=> sel_n.upper_n && sel_n.lower_n;
  endproperty
  a_io: assert property (p_io) else $error("memory select on io");
  property p_upper;
    cyc_start && !cyc_busy && !cyc_req.is_io && cyc_req.addr[19:16] == 4'hf
      |=> !sel_n.upper_n;
  endproperty
  a_upper: assert property (p_upper) else $error("top block not upper");
  property p_rsvd;
    $past(reg_rd) && $past(reg_addr) == 8'ha0 |-> (reg_rdata & 16'h8f70) == 16'h8030;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("upper reserved bits");
  property p_strap; !rst_ff && !strap_ff |-> addr_phase_enable; endproperty
  a_strap: assert property (p_strap) else $error("address phase dropped");
  c_upper: cover property (!sel_n.upper_n);
  c_periph: cover property (!(&sel_n.periph_n));
  c_unmap: cover property (cyc_unmapped);
endmodule : csw_unit_chk

bind csw_unit csw_unit_chk u_csw_unit_chk (
  .core_clk(core_clk), .srst(srst), .reg_addr(reg_addr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .addr_phase_strap_pin(addr_phase_strap_pin),
  .cyc_start(cyc_start), .cyc_req(cyc_req), .sel_n(sel_n),
  .addr_phase_enable(addr_phase_enable), .cyc_busy(cyc_busy),
  .cyc_unmapped(cyc_unmapped)
);
`default_nettype wire

// ===== csw_mem_model.sv
// far-side device model that stretches cycles through ready
`default_nettype none
module csw_mem_model
  import csw_pkg::*;
(
  input  wire logic       core_clk,
  input  wire csw_sel_s   sel_n,
  input  wire logic [5:0] stall_len,
  output var  logic       external_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [6:0] cnt_ff = 7'h00;
  // ====================
  // count cycles the device is selected
  always_ff @(posedge core_clk) begin
    cnt_ff <= (&sel_n) ? 7'h00 : cnt_ff + 7'h01;
  end
  // low to stretch while selected, pull-up when idle
  assign external_ready = (&sel_n) || (cnt_ff >= {1'b0, stall_len});
endmodule : csw_mem_model
`default_nettype wire

// ===== csw_unit_bench.sv
// self-checking bench for the chip select unit
`default_nettype none
module csw_unit_bench
  import csw_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  logic        core_clk, srst, reg_wr, reg_rd, strap, cyc_start;
  logic        ape, ape_q, busy, done, unmap, ext_rdy;
  logic [7:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, d;
  logic [5:0]  stall;
  csw_req_s    cyc_req;
  csw_sel_s    sel_n, sel_q;
  int          fail_count, total_checks, lat, w, r, s, e;
  logic [2:0]  blk[4] = '{3'd7, 3'd6, 3'd4, 3'd0};
  logic [19:0] top[4] = '{20'hf0000, 20'he0000, 20'hc0000, 20'h80000};
  csw_unit u_csw_unit (.core_clk(core_clk), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .addr_phase_strap_pin(strap), .cyc_start(cyc_start), .cyc_req(cyc_req),
    .external_ready(ext_rdy), .sel_n(sel_n), .addr_phase_enable(ape),
    .cyc_busy(busy), .cyc_done(done), .cyc_unmapped(unmap));
  csw_mem_model u_csw_mem_model (.core_clk(core_clk), .sel_n(sel_n),
    .stall_len(stall), .external_ready(ext_rdy));
  // ====================
  // clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // ====================
  // helpers
  function automatic int wt(input logic [2:0] c, input logic p);
    int t[8] = '{0, 1, 2, 3, 5, 7, 9, 15};
    return (p && c == 3'd7) ? 11 : t[c];
  endfunction : wt
  task automatic report_and_stop();
    $display("checks %0d errors %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t got %0h exp %0h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd
  task automatic cyc(input logic [19:0] a, input logic io);
    int n;
    @(posedge core_clk);
    cyc_start <= 1'b1;
    cyc_req <= '{io, a};
    @(posedge core_clk);
    cyc_start <= 1'b0;
    #1;
    sel_q = sel_n;
    ape_q = ape;
    for (n = 0; done !== 1'b1; n++) begin
      if (n > 300) begin
        fail_count++;
        report_and_stop();
      end
      @(posedge core_clk);
      #1;
    end
    lat = n;
  endtask : cyc
  task automatic do_reset(input logic sv);
    @(posedge core_clk);
    srst <= 1'b1;
    strap <= sv;
    repeat (4) @(posedge core_clk);
    srst <= 1'b0;
    repeat (2) @(posedge core_clk);
  endtask : do_reset
  // ====================
  // main sequence
  initial begin
    {srst, reg_wr, reg_rd, cyc_start, strap} = 5'b10001;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    cyc_req = '0;
    stall = 6'h00;
    s = $urandom(45);
    do_reset(1'b1);
    rd(UPPER_OFS);
    chk(d, 16'hf03b);
    rd(8'hb0);
    chk(d, 16'h0000);
    cyc(20'hffff0, 1'b0);
    chk(lat, 20);
    stall = 6'd40;
    cyc(20'hf1234, 1'b0);
    chk(lat > 20, 1'b1);
    cyc(20'h01000, 1'b0);
    chk(sel_q.lower_n, 1'b1);
    rd(LOWER_OFS);
    chk(d, 16'h003f);
    cyc(20'h01000, 1'b0);
    chk(sel_q.lower_n, 1'b0);
    for (int c = 0; c < 8; c++) begin
      stall = 6'($urandom_range(0, 40));
      wr(UPPER_OFS, {12'h700, c[2], 1'b1, c[1:0]});
      cyc(20'hf0000 | 20'($urandom_range(0, 16'hffff)), 1'b0);
      chk(lat, 5 + wt(3'(c), 1'b0));
      chk(ape_q, 1'b1);
    end
    rd(UPPER_OFS);
    chk(d, 16'hf03f);
    for (int i = 0; i < 4; i++) begin
      wr(UPPER_OFS, {1'b0, blk[i], 12'h084});
      cyc(top[i], 1'b0);
      chk(sel_q.upper_n, 1'b0);
      chk(ape_q, 1'b0);
      cyc(top[i] - 20'h1, 1'b0);
      chk(sel_q.lower_n, 1'b0);
      chk(ape_q, 1'b1);
    end
    wr(LOWER_OFS, 16'h0080);
    cyc(20'h00100, 1'b0);
    chk(ape_q, 1'b0);
    w = $urandom_range(0, 7);
    r = $urandom_range(0, 7);
    s = $urandom_range(0, 3);
    // io-mapped block with base top bits zero
    wr(PERIPH0_OFS, {8'h02, 1'b0, 3'(w), 1'(r >> 2), 1'b1, 2'(r)});
    cyc(20'h02000, 1'b1);
    chk(sel_q.periph_n, 6'h3f);
    wr(PERIPH1_OFS, {13'h0000, 1'b1, 2'(s)});
    rd(PERIPH1_OFS);
    chk(d, {13'h0007, 1'b1, 2'(s)});
    for (int n = 0; n < 6; n++) begin
      stall = 6'($urandom_range(0, 40));
      cyc(20'h02000 + 20'(n * 256) + 20'($urandom_range(0, 255)), 1'b1);
      chk(sel_q.periph_n, (n == 4) ? 6'h3f : 6'(~(6'h01 << n)));
      e = (n == 5) ? s : wt(3'(r), 1'b0);
      e = (n == 4) ? 5 : 5 + wt(3'(w), 1'b1) + e;
      chk(lat, e);
    end
    cyc(20'h02000, 1'b0);
    chk(sel_q.periph_n, 6'h3f);
    do_reset(1'b0);
    wr(UPPER_OFS, 16'h7084);
    cyc(20'hf0000, 1'b0);
    chk(ape_q, 1'b1);
    report_and_stop();
  end
endmodule : csw_unit_bench
`default_nettype wire
